// ==== core/programmable_crc_generator.sv ====
`include "crc_consts.svh"

module programmable_crc_generator (
  input  wire logic              mclk_i,     // 250 MHz clock
  input  wire logic              resetn_i,   // async reset, active low
  input  wire logic              sleep_i,    // device in sleep
  input  wire logic              idle_i,     // device in idle
  input  wire crc_pkg::bus_req_t bus_req_i,  // register port request
  output logic [15:0]            rdata_o,    // read data, cycle after read
  output logic                   irq_o       // level interrupt
);

  // control fields
  logic                  idle_stop;             // halt in idle
  logic                  shifter_run;           // run bit
  logic [3:0]            poly_length_minus_one; // length field
  logic [15:1]           crc_polynomial_taps;   // feedback taps
  logic [1:0]            int_status;            // sticky events
  logic [1:0]            int_mask;              // interrupt enables
  logic [15:0]           stage;                 // byte staging word
  logic                  next_idle_stop;
  logic                  next_shifter_run;
  logic [3:0]            next_poly_length_minus_one;
  logic [15:1]           next_taps;
  logic [1:0]            next_int_status;
  logic [1:0]            next_int_mask;
  logic [15:0]           next_stage;
  logic [15:0]           next_rdata;
  logic                  next_irq;

  // fifo state
  logic [15:0]           mem [16];              // word storage
  logic [15:0]           next_mem [16];
  logic [3:0]            wptr;                  // write pointer
  logic [3:0]            rptr;                  // read pointer
  logic [4:0]            fifo_valid_word_count; // valid words
  logic [3:0]            next_wptr;
  logic [3:0]            next_rptr;
  logic [4:0]            next_count;

  // engine state
  crc_pkg::eng_state_t   state;                 // engine state
  crc_pkg::eng_state_t   next_state;
  logic [15:0]           sh;                    // data being shifted
  logic [4:0]            bits_left;             // data bits still to go
  logic [15:0]           crc_result_register;   // running checksum
  logic [15:0]           next_sh;
  logic [4:0]            next_bits_left;
  logic [15:0]           next_crc;

  // shared decode
  logic                  halt;           // module clocks stopped
  logic [4:0]            depth;          // active fifo depth
  logic [3:0]            last_slot;      // highest pointer value
  logic [15:0]           wmask;          // polynomial width mask
  logic                  fifo_full_flag; // count at depth
  logic                  fifo_empty_flag;// count at zero
  logic                  wr_data_hit;    // write to data-write reg
  logic                  push;           // word completes
  logic                  overflow;       // push while full
  logic                  take;           // word moves to engine
  logic [15:0]           push_word;      // assembled, masked word
  logic                  drain_evt;      // count 1 to 0
  logic                  done_evt;       // engine ran dry

  // one lfsr step, msb-first input bit
  function automatic logic [15:0] crc_step(
    input logic [15:0] c,
    input logic        d,
    input logic [15:1] t,
    input logic [3:0]  top,
    input logic [15:0] m
  );
    logic        fb;
    logic [15:0] s;
    fb = c[top] ^ d;
    // shifting out the top stage is the implied highest term
    s = (c << 1) & m;
    if (fb) begin
      s = s ^ ({t, 1'b1} & m);
    end
    return s;
  endfunction

  // shared decode of length, depth and strobes
  always_comb begin
    // sleep always halts; idle only when asked to stop
    halt = sleep_i | (idle_i & idle_stop);
    for (int i = 0; i < 16; i++) begin
      wmask[i] = (4'(i) <= poly_length_minus_one);
    end
    depth = (poly_length_minus_one > `CRC_LEN_SPLIT) ?
            `CRC_DEPTH_LONG : `CRC_DEPTH_SHORT;
    last_slot = 4'(depth - 5'h01);
    fifo_full_flag  = (fifo_valid_word_count == depth);
    fifo_empty_flag = (fifo_valid_word_count == 5'h00);
    wr_data_hit = bus_req_i.wr &&
                  (bus_req_i.addr == `CRC_OFS_WDATA);
    // the word completes when its top byte lane is written
    if (poly_length_minus_one > `CRC_LEN_SPLIT) begin
      push = wr_data_hit && bus_req_i.be[1] && !halt;
    end else begin
      push = wr_data_hit && bus_req_i.be[0] && !halt;
    end
    push_word[15:8] = bus_req_i.be[1] ? bus_req_i.wdata[15:8]
                                      : stage[15:8];
    push_word[7:0]  = bus_req_i.be[0] ? bus_req_i.wdata[7:0]
                                      : stage[7:0];
    push_word = push_word & wmask;
    overflow = push && fifo_full_flag;
    // reload the engine as it finishes so words run back to back
    take = shifter_run && !fifo_empty_flag && !halt &&
           ((state == crc_pkg::ENG_IDLE) ||
            (bits_left <= `CRC_BITS_PER_CLK));
    drain_evt = take && !push && !overflow &&
                (fifo_valid_word_count == 5'h01);
  end

  // fifo next state: pointers, count, storage
  always_comb begin
    next_mem   = mem;
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = fifo_valid_word_count;
    if (overflow) begin
      // count wraps; fifo behaves empty and the word is lost
      next_wptr  = 4'h0;
      next_rptr  = 4'h0;
      next_count = 5'h00;
    end else begin
      if (push) begin
        next_mem[wptr] = push_word;
        next_wptr = (wptr == last_slot) ? 4'h0 : wptr + 4'h1;
      end
      if (take) begin
        next_rptr = (rptr == last_slot) ? 4'h0 : rptr + 4'h1;
      end
      // count shows the push one cycle after the write
      if (push && !take) begin
        next_count = fifo_valid_word_count + 5'h01;
      end else if (take && !push) begin
        next_count = fifo_valid_word_count - 5'h01;
      end
    end
  end

  // fifo registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      fifo_valid_word_count <= 5'h00;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      fifo_valid_word_count <= next_count;
    end
  end

  // storage needs no reset; empty slots are never read
  always_ff @(posedge mclk_i) begin
    mem <= next_mem;
  end

  // engine next state: two lfsr steps per clock, one when a single bit is left
  always_comb begin
    next_state     = state;
    next_sh        = sh;
    next_bits_left = bits_left;
    next_crc       = crc_result_register;
    if (!halt) begin
      if (state == crc_pkg::ENG_SHIFT) begin
        next_crc = crc_step(crc_result_register,
                            sh[poly_length_minus_one],
                            crc_polynomial_taps,
                            poly_length_minus_one, wmask);
        if (bits_left >= `CRC_BITS_PER_CLK) begin
          // second bit of the pair in the same clock
          next_crc = crc_step(next_crc,
                              sh[poly_length_minus_one - 4'h1],
                              crc_polynomial_taps,
                              poly_length_minus_one, wmask);
          next_bits_left = bits_left - `CRC_BITS_PER_CLK;
        end else begin
          next_bits_left = 5'h00;
        end
        next_sh = sh << 2;
        if (next_bits_left == 5'h00) begin
          next_state = crc_pkg::ENG_IDLE;
        end
      end
      if (take) begin
        next_sh        = mem[rptr];
        next_bits_left = {1'b0, poly_length_minus_one} + 5'h01;
        next_state     = crc_pkg::ENG_SHIFT;
      end
    end
    // software seeds the checksum through the result register
    if (bus_req_i.wr && (bus_req_i.addr == `CRC_OFS_RESULT)) begin
      next_crc = bus_req_i.wdata & wmask;
    end
    done_evt = (state == crc_pkg::ENG_SHIFT) &&
               (next_state == crc_pkg::ENG_IDLE);
  end

  // engine registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state               <= crc_pkg::ENG_IDLE;
      sh                  <= 16'h0000;
      bits_left           <= 5'h00;
      crc_result_register <= 16'h0000;
    end else begin
      state               <= next_state;
      sh                  <= next_sh;
      bits_left           <= next_bits_left;
      crc_result_register <= next_crc;
    end
  end

  // register file next state, read mux and interrupt
  always_comb begin
    next_idle_stop             = idle_stop;
    next_shifter_run           = shifter_run;
    next_poly_length_minus_one = poly_length_minus_one;
    next_taps                  = crc_polynomial_taps;
    next_int_mask              = int_mask;
    next_int_status            = int_status;
    next_stage                 = stage;
    next_rdata                 = 16'h0000;
    if (bus_req_i.wr) begin
      case (bus_req_i.addr)
        `CRC_OFS_CTRL: begin
          if (bus_req_i.be[0]) begin
            next_shifter_run = bus_req_i.wdata[`CRC_BIT_RUN];
            next_poly_length_minus_one = bus_req_i.wdata[3:0];
          end
          if (bus_req_i.be[1]) begin
            next_idle_stop = bus_req_i.wdata[`CRC_BIT_IDLE_STOP];
          end
        end
        `CRC_OFS_TAPS: begin
          // bit 0 has no storage; the constant term is fixed
          if (bus_req_i.be[0]) begin
            next_taps[7:1] = bus_req_i.wdata[7:1];
          end
          if (bus_req_i.be[1]) begin
            next_taps[15:8] = bus_req_i.wdata[15:8];
          end
        end
        `CRC_OFS_WDATA: begin
          // keep partial bytes until the top lane arrives
          next_stage = push_word;
        end
        `CRC_OFS_INT_MASK: begin
          if (bus_req_i.be[0]) begin
            next_int_mask = bus_req_i.wdata[1:0];
          end
        end
        default: begin
          next_stage = stage;
        end
      endcase
    end
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        `CRC_OFS_CTRL: begin
          next_rdata = {2'b00, idle_stop, fifo_valid_word_count,
                        fifo_full_flag, fifo_empty_flag, 1'b0,
                        shifter_run, poly_length_minus_one};
        end
        `CRC_OFS_TAPS: begin
          next_rdata = {crc_polynomial_taps, 1'b0};
        end
        `CRC_OFS_RESULT, `CRC_OFS_WDATA: begin
          // valid only once drained and the engine has finished
          next_rdata = crc_result_register;
        end
        `CRC_OFS_INT_STAT: begin
          next_rdata = {14'h0000, int_status};
          next_int_status = 2'b00;
        end
        `CRC_OFS_INT_MASK: begin
          next_rdata = {14'h0000, int_mask};
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
    // set after clear so an event in the read cycle survives;
    // no event reaches the flag while halted, since take and shifting both stop
    if (drain_evt) begin
      next_int_status[`CRC_INT_DRAIN] = 1'b1;
    end
    if (done_evt) begin
      next_int_status[`CRC_INT_DONE] = 1'b1;
    end
    next_irq = |(next_int_status & next_int_mask);
  end

  // register file flops
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_stop             <= 1'b0;
      shifter_run           <= 1'b0;
      poly_length_minus_one <= `CRC_LEN_RESET;
      crc_polynomial_taps   <= `CRC_TAPS_RESET;
      int_mask              <= `CRC_MASK_RESET;
      int_status            <= 2'b00;
      stage                 <= 16'h0000;
      rdata_o               <= 16'h0000;
      irq_o                 <= 1'b0;
    end else begin
      idle_stop             <= next_idle_stop;
      shifter_run           <= next_shifter_run;
      poly_length_minus_one <= next_poly_length_minus_one;
      crc_polynomial_taps   <= next_taps;
      int_mask              <= next_int_mask;
      int_status            <= next_int_status;
      stage                 <= next_stage;
      rdata_o               <= next_rdata;
      irq_o                 <= next_irq;
    end
  end

  // checks, all on the one clock
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_last_pop;
    drain_evt;
  endsequence

  sequence s_load_full_width;
    take && (poly_length_minus_one == 4'hf);
  endsequence

  a_result_width: assert property (
    (state == crc_pkg::ENG_SHIFT) && $stable(poly_length_minus_one)
    |=> (crc_result_register & ~wmask) == 16'h0000)
    else $error("checksum has bits above polynomial width");

  a_count_bound: assert property (
    $stable(poly_length_minus_one) |-> fifo_valid_word_count <= depth)
    else $error("valid word count above fifo depth");

  a_push_counts: assert property (
    push && !take && !fifo_full_flag
    |=> fifo_valid_word_count == $past(fifo_valid_word_count) + 5'h01)
    else $error("completed word did not raise the count");

  a_take_loads: assert property (
    take && !push
    |=> (state == crc_pkg::ENG_SHIFT) &&
        (fifo_valid_word_count == $past(fifo_valid_word_count) - 5'h01))
    else $error("transfer did not load engine and decrement");

  a_two_bits_clk: assert property (
    s_load_full_width ##1 (!halt && !take)[*2]
    |=> bits_left == 5'h0c)
    else $error("engine not shifting two bits per clock");

  a_full_flag_read: assert property (
    bus_req_i.rd && (bus_req_i.addr == `CRC_OFS_CTRL) &&
    (fifo_valid_word_count == depth)
    |=> rdata_o[`CRC_BIT_FULL] && !rdata_o[`CRC_BIT_EMPTY])
    else $error("full flag not shown at depth");

  a_overflow_wrap: assert property (
    overflow |=> (fifo_valid_word_count == 5'h00) &&
                 !$rose(int_status[`CRC_INT_DRAIN]))
    else $error("overflow did not wrap count quietly");

  a_drain_irq: assert property (
    s_last_pop |=> int_status[`CRC_INT_DRAIN] &&
                   (irq_o || !int_mask[`CRC_INT_DRAIN]))
    else $error("drain did not raise interrupt");

  a_run_gate: assert property (
    !shifter_run && !overflow |=> $stable(rptr))
    else $error("fifo drained with run bit clear");

  a_sleep_freeze: assert property (
    sleep_i && !(bus_req_i.wr && (bus_req_i.addr == `CRC_OFS_RESULT))
    |=> $stable(crc_result_register) && $stable(bits_left) &&
        $stable(fifo_valid_word_count))
    else $error("module state moved during sleep");

  a_idle_stop: assert property (
    idle_i && idle_stop && !sleep_i |=> $stable(fifo_valid_word_count))
    else $error("module ran in idle with idle stop set");

  a_tap_zero_read: assert property (
    bus_req_i.rd && (bus_req_i.addr == `CRC_OFS_TAPS) |=> !rdata_o[0])
    else $error("tap bit zero read as one");

endmodule

// ==== pkg/crc_consts.svh ====
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// register offsets on the plain register port
`define CRC_OFS_CTRL      4'h0
`define CRC_OFS_TAPS      4'h2
`define CRC_OFS_RESULT    4'h4
`define CRC_OFS_WDATA     4'h6
`define CRC_OFS_INT_STAT  4'h8
`define CRC_OFS_INT_MASK  4'ha

// control/status field positions
`define CRC_BIT_IDLE_STOP 13
`define CRC_BIT_COUNT_LO  8
`define CRC_BIT_FULL      7
`define CRC_BIT_EMPTY     6
`define CRC_BIT_RUN       4

// interrupt status bit positions
`define CRC_INT_DRAIN     0
`define CRC_INT_DONE      1

// reset values
`define CRC_TAPS_RESET    15'h0000
`define CRC_MASK_RESET    2'h0
`define CRC_LEN_RESET     4'h0

// fifo depth selection and shift rate
`define CRC_LEN_SPLIT     4'h7
`define CRC_DEPTH_LONG    5'h08
`define CRC_DEPTH_SHORT   5'h10
`define CRC_BITS_PER_CLK  5'h02

`endif

// ==== pkg/crc_pkg.sv ====
package crc_pkg;

  // one register port request, sampled every clock
  typedef struct packed {
    logic [3:0]  addr;   // register offset
    logic [15:0] wdata;  // write data
    logic [1:0]  be;     // write byte lanes
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } bus_req_t;

  // shift engine states
  typedef enum logic [0:0] {
    ENG_IDLE  = 1'b0,
    ENG_SHIFT = 1'b1
  } eng_state_t;

endpackage

// ==== testbench/tb_top.sv ====
`include "crc_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk_i;     // 250 MHz bench clock
  logic              resetn_i;   // async reset, active low
  logic              sleep_i;    // device sleep
  logic              idle_i;     // device idle
  crc_pkg::bus_req_t bus_req_i;  // register port request
  logic [15:0]       rdata_o;    // read data, cycle after read
  logic              irq_o;      // level interrupt
  logic [15:0]       exp_q[$];   // expected read data, oldest first
  logic              rd_q;       // a read was taken at the last edge
  int                failures;   // mismatch count
  int                checked;    // comparison count

  programmable_crc_generator i_programmable_crc_generator (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .sleep_i   (sleep_i),
    .idle_i    (idle_i),
    .bus_req_i (bus_req_i),
    .rdata_o   (rdata_o),
    .irq_o     (irq_o)
  );

  // free-running clock, 4 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // remember which edges took a read
  always @(posedge mclk_i) begin
    rd_q <= bus_req_i.rd;
  end

  // read data stands for one cycle only, so sample it mid-cycle
  always @(negedge mclk_i) begin
    if (rd_q === 1'b1) begin
      checked++;
      if (exp_q.size() == 0 || rdata_o !== exp_q[0]) begin
        failures++;
        $display("mismatch at %0t: read data %h", $time, rdata_o);
      end
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
      end
    end else if (resetn_i === 1'b1 && rdata_o !== 16'h0000) begin
      // read data must fall back to zero outside the answer cycle
      checked++;
      failures++;
      $display("mismatch at %0t: stray read data %h", $time, rdata_o);
    end
  end

  // verdict and end of run
  task automatic stop_test();
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one strobe cycle, then an idle cycle
  task automatic bus_op(input logic [3:0] a, input logic [15:0] d,
                        input logic [1:0] be, input logic w);
    @(posedge mclk_i);
    bus_req_i <= '{addr: a, wdata: d, be: be, wr: w, rd: ~w};
    @(posedge mclk_i);
    bus_req_i <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    bus_op(a, d, be, 1'b1);
  endtask

  // the note goes in before the strobe, so the monitor finds it
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus_op(a, 16'h0000, 2'h0, 1'b0);
  endtask

  // irq is registered, so look at it away from the edge
  task automatic check_irq(input logic e);
    @(negedge mclk_i);
    checked++;
    if (irq_o !== e) begin
      failures++;
      $display("mismatch at %0t: interrupt level %b", $time, irq_o);
    end
  endtask

  // bounded wait for the interrupt to rise
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 400) begin
      failures++;
      $display("mismatch at %0t: interrupt never rose", $time);
      stop_test();
    end
  endtask

  // reference checksum, msb first, no reflection
  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic [15:0] d, input logic [15:0] taps, input int n);
    logic [15:0] m;
    logic        fb;
    m = 16'hffff >> (16 - n);
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[n - 1] ^ d[i];
      c = ((c << 1) & m) ^ (fb ? ({taps[15:1], 1'b1} & m) : 16'h0000);
    end
    return c;
  endfunction

  function automatic logic [15:0] ctrl_val(input logic idle,
      input logic [4:0] cnt, input logic full, input logic run,
      input logic [3:0] len);
    return {2'b00, idle, cnt, full, cnt == 5'h00, 1'b0, run, len};
  endfunction

  // load words, optionally hold the block halted, drain, check result
  // halt: 0 none, 1 sleep, 2 idle with idle_stop set
  task automatic crc_run(input logic [3:0] len, input int words,
                         input int halt);
    logic [15:0] taps;
    logic [15:0] seed;
    logic [15:0] d;
    logic [15:0] c;
    logic [15:0] m;
    logic        full;
    int          n;
    n = len + 1;
    m = 16'hffff >> (16 - n);
    full = (words == ((len > 4'h7) ? 8 : 16));
    taps = 16'($urandom());
    seed = 16'($urandom());
    c = seed & m;
    wr(`CRC_OFS_CTRL, {12'h000, len}, 2'h3);
    wr(`CRC_OFS_TAPS, taps, 2'h3);
    rd(`CRC_OFS_TAPS, taps & 16'hfffe);
    wr(`CRC_OFS_RESULT, seed, 2'h3);
    for (int i = 0; i < words; i++) begin
      d = 16'($urandom());
      if (len > 4'h7) begin
        // low lane only stages; the top lane write pushes the word
        wr(`CRC_OFS_WDATA, d, 2'h1);
        wr(`CRC_OFS_WDATA, {d[15:8], ~d[7:0]}, 2'h2);
      end else begin
        wr(`CRC_OFS_WDATA, d, 2'h1);
      end
      c = crc_step(c, d & m, taps, n);
    end
    // the bus idle cycle gives the count its cycle to settle
    rd(`CRC_OFS_CTRL,
       ctrl_val(1'b0, 5'(words), full, 1'b0, len));
    if (halt == 1) begin
      @(posedge mclk_i);
      sleep_i <= 1'b1;
    end else if (halt == 2) begin
      @(posedge mclk_i);
      idle_i <= 1'b1;
    end
    // fifo is preloaded before the shifter starts
    wr(`CRC_OFS_CTRL, ctrl_val(halt == 2, 5'h00, 1'b0, 1'b1, len) & 16'h201f,
       2'h3);
    if (halt != 0) begin
      repeat (20) @(posedge mclk_i);
      // nothing may move while halted
      rd(`CRC_OFS_CTRL,
         ctrl_val(halt == 2, 5'(words), full, 1'b1, len));
      check_irq(1'b0);
      if (halt == 1) begin
        @(posedge mclk_i);
        sleep_i <= 1'b0;
      end else begin
        // idle continues, but the block now keeps running
        wr(`CRC_OFS_CTRL, {11'h000, 1'b1, len}, 2'h3);
      end
    end
    wait_irq();
    // the last word still shifts after the drain event
    repeat (n / 2 + 4) @(posedge mclk_i);
    rd(`CRC_OFS_CTRL, ctrl_val(1'b0, 5'h00, 1'b0, 1'b1, len));
    rd(`CRC_OFS_RESULT, c);
    rd(`CRC_OFS_WDATA, c);
    rd(`CRC_OFS_INT_STAT, 16'h0003);
    check_irq(1'b0);
    @(posedge mclk_i);
    idle_i <= 1'b0;
  endtask

  initial begin
    failures = 0;
    checked = 0;
    sleep_i = 1'b0;
    idle_i = 1'b0;
    bus_req_i = '0;
    resetn_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    void'($urandom(17818));
    // reset values, unmapped address reads zero
    rd(`CRC_OFS_CTRL, 16'h0040);
    rd(`CRC_OFS_TAPS, 16'h0000);
    rd(`CRC_OFS_INT_MASK, 16'h0000);
    rd(4'hc, 16'h0000);
    wr(`CRC_OFS_INT_MASK, 16'h0001, 2'h3);
    rd(`CRC_OFS_INT_MASK, 16'h0001);
    crc_run(4'hf, 3, 0);
    crc_run(4'h4, 5, 1);
    crc_run(4'h7, 16, 2);
    crc_run(4'h8, 8, 0);
    for (int k = 0; k < 4; k++) begin
      crc_run(4'($urandom()), 1 + int'($urandom() % 3), 0);
    end
    // overflow: one word past full wraps to empty, no event
    wr(`CRC_OFS_CTRL, 16'h0008, 2'h3);
    for (int i = 0; i < 9; i++) begin
      wr(`CRC_OFS_WDATA, 16'($urandom()), 2'h3);
    end
    rd(`CRC_OFS_CTRL, ctrl_val(1'b0, 5'h00, 1'b0, 1'b0, 4'h8));
    rd(`CRC_OFS_INT_STAT, 16'h0000);
    check_irq(1'b0);
    // masked events still latch status but keep irq low
    wr(`CRC_OFS_INT_MASK, 16'h0000, 2'h3);
    wr(`CRC_OFS_WDATA, 16'h1234, 2'h3);
    wr(`CRC_OFS_CTRL, 16'h0018, 2'h3);
    repeat (20) @(posedge mclk_i);
    check_irq(1'b0);
    rd(`CRC_OFS_INT_STAT, 16'h0003);
    rd(`CRC_OFS_INT_STAT, 16'h0000);
    repeat (4) @(posedge mclk_i);
    stop_test();
  end
endmodule
